// file: cax_pkg.sv
// constants, field layouts and types for the add-and-shift execute datapath
// assumes one core clock; the decode logic upstream delivers 14-bit words
//
// How it works
// - pc change or true test: two cycles, nop
// - indirect port, pointer msb set: one more
// - pointer add: signed 6-bit literal, flags kept
// - pointer sums wrap modulo 65536, no saturation
// - literal add to accumulator, sets c dc z
// - accumulator plus file, destination bit routes
// - accumulator plus file plus carry, routed
// - literal and into accumulator, zero only
// - file and accumulator, routed, zero only
// - shift right keeps bit7, bit0 to carry
// - pointer add word: 11 0001 0n kkkkkk
// - literal add word: 11 1110 kkkkkkkk
// - literal and word: 11 1001 kkkkkkkk
package cax_pkg;

    // datapath widths
    localparam int OPW = 14;
    localparam int DW  = 8;
    localparam int PW  = 16;
    localparam int FW  = 7;
    localparam int AW  = 12;

    // instruction word fields
    localparam logic [5:0] OP_ADD_LIT_ACC = 6'h3E;  // 11 1110
    localparam logic [5:0] OP_AND_LIT_ACC = 6'h39;  // 11 1001
    localparam logic [6:0] OP_ADD_LIT_PTR = 7'h62;  // 11 0001 0
    localparam int         DEST_BIT       = 7;
    localparam int         PSEL_BIT       = 6;

    // file-operation major codes, overridable at the top
    localparam logic [5:0] OP_ADD_ACC_FILE_DEF = 6'h07;
    localparam logic [5:0] OP_ADC_FILE_DEF     = 6'h3D;
    localparam logic [5:0] OP_AND_ACC_FILE_DEF = 6'h05;
    localparam logic [5:0] OP_ASR_FILE_DEF     = 6'h37;

    // file addresses that act as the indirect access ports
    localparam logic [FW-1:0] IND_PORT0_ADDR = 7'h00;
    localparam logic [FW-1:0] IND_PORT1_ADDR = 7'h01;

    // status bit positions
    localparam int ST_C_BIT  = 0;
    localparam int ST_DC_BIT = 1;
    localparam int ST_Z_BIT  = 2;

    // apb register byte offsets
    localparam logic [AW-1:0] REG_ACC  = 12'h000;
    localparam logic [AW-1:0] REG_STAT = 12'h004;
    localparam logic [AW-1:0] REG_PTR0 = 12'h008;
    localparam logic [AW-1:0] REG_PTR1 = 12'h00C;
    localparam logic [AW-1:0] REG_INFO = 12'h010;

    // reset values
    localparam logic [DW-1:0] ACC_RST  = 8'h00;
    localparam logic [2:0]    STAT_RST = 3'h0;
    localparam logic [PW-1:0] PTR_RST  = 16'h0000;

    // timing in instruction cycles
    localparam logic [1:0] CYC_BASE = 2'h1;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} cax_state_t;

endpackage : cax_pkg

// file: cax_exec.sv
// execute stage for add, add with carry, and, shift right and pointer add
// assumes a register file that returns file_rdata combinationally from
// mem_addr, and an apb master on the same clock
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module cax_exec
    import cax_pkg::*;
#(
    parameter logic [5:0] OP_ADD_ACC_FILE = OP_ADD_ACC_FILE_DEF,
    parameter logic [5:0] OP_ADC_FILE     = OP_ADC_FILE_DEF,
    parameter logic [5:0] OP_AND_ACC_FILE = OP_AND_ACC_FILE_DEF,
    parameter logic [5:0] OP_ASR_FILE     = OP_ASR_FILE_DEF
)
(
    input  wire logic           clk,             // core clock
    input  wire logic           resetn,          // async reset, low
    input  wire logic           instr_valid,     // decode offers a word
    input  wire logic [OPW-1:0] instr_word,      // 14-bit instruction
    input  wire logic           instr_pc_change, // pc altered or test true
    output var  logic           instr_ready,     // word taken when high
    input  wire logic [DW-1:0]  file_rdata,      // addressed file value
    output var  logic [PW-1:0]  mem_addr,        // file or pointer address
    output var  logic           mem_indirect,    // address is a pointer
    output var  logic           mem_we,          // file write pulse
    output var  logic [DW-1:0]  mem_wdata,       // file write data
    output var  logic           done,            // instruction retired
    output var  logic [1:0]     done_cycles,     // its instruction cycles
    input  wire logic           psel,            // apb select
    input  wire logic           penable,         // apb access phase
    input  wire logic           pwrite,          // apb direction
    input  wire logic [AW-1:0]  paddr,           // apb byte address
    input  wire logic [31:0]    pwdata,          // apb write data
    output var  logic [31:0]    prdata,          // apb read data
    output var  logic           pready,          // apb ready
    output var  logic           pslverr          // apb error
);

    cax_state_t       state_r, state_nxt;
    logic [OPW-1:0]   ir_r, ir_nxt;
    logic             pcx_r, pcx_nxt;
    logic             indx_r, indx_nxt;
    logic [1:0]       cnt_r, cnt_nxt;
    logic [DW-1:0]    acc_r, acc_nxt;
    logic [2:0]       stat_r, stat_nxt;
    logic [PW-1:0]    ptr_r [0:1];
    logic [PW-1:0]    ptr_nxt [0:1];
    logic             ready_r, ready_nxt;
    logic [PW-1:0]    maddr_r, maddr_nxt;
    logic             mind_r, mind_nxt;
    logic             mwe_r, mwe_nxt;
    logic [DW-1:0]    mwd_r, mwd_nxt;
    logic             done_r, done_nxt;
    logic [1:0]       dcyc_r, dcyc_nxt;
    logic [31:0]      prdata_r, prdata_nxt;
    logic             pready_r, pready_nxt;
    logic             pslverr_r, pslverr_nxt;

    // read view of the registers; unmapped offsets flag an error
    logic [31:0] rd_val;
    logic        rd_hit;
    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            REG_ACC:  rd_val = {24'h00_0000, acc_r};
            REG_STAT: rd_val = {29'h0000_0000, stat_r};
            REG_PTR0: rd_val = {16'h0000, ptr_r[0]};
            REG_PTR1: rd_val = {16'h0000, ptr_r[1]};
            REG_INFO: rd_val = {29'h0000_0000, state_r != ST_IDLE, dcyc_r};
            default:  rd_hit = 1'b0;
        endcase
    end

    // next-state logic for the engine and the apb slave
    always_comb
    begin
        logic [5:0]    top6;
        logic [FW-1:0] fa;
        logic          dst;
        logic [DW-1:0] opb;
        logic          cin;
        logic [DW:0]   sum9;
        logic [4:0]    sum5;
        logic [DW-1:0] res;
        logic          wr_en;
        logic          upd_c;
        logic          upd_dc;
        logic          upd_z;
        logic          new_c;
        logic          is_arith;
        logic [1:0]    ext;
        logic          ind;
        logic          pn;
        logic [PW-1:0] kx;
        top6     = 6'h00;
        fa       = '0;
        dst      = 1'b0;
        opb      = '0;
        cin      = 1'b0;
        sum9     = '0;
        sum5     = '0;
        res      = '0;
        wr_en    = 1'b0;
        upd_c    = 1'b0;
        upd_dc   = 1'b0;
        upd_z    = 1'b0;
        new_c    = 1'b0;
        is_arith = 1'b0;
        ext      = 2'h0;
        ind      = 1'b0;
        pn       = 1'b0;
        kx       = '0;

        state_nxt   = state_r;
        ir_nxt      = ir_r;
        pcx_nxt     = pcx_r;
        indx_nxt    = indx_r;
        cnt_nxt     = cnt_r;
        acc_nxt     = acc_r;
        stat_nxt    = stat_r;
        ptr_nxt[0]  = ptr_r[0];
        ptr_nxt[1]  = ptr_r[1];
        maddr_nxt   = maddr_r;
        mind_nxt    = mind_r;
        mwe_nxt     = 1'b0;
        mwd_nxt     = mwd_r;
        done_nxt    = 1'b0;
        dcyc_nxt    = dcyc_r;
        prdata_nxt  = prdata_r;
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;

        case (state_r)
            ST_IDLE:
            begin
                if (instr_valid && ready_r)
                begin
                    // latch word and present the operand address
                    ir_nxt    = instr_word;
                    pcx_nxt   = instr_pc_change;
                    fa        = instr_word[FW-1:0];
                    ind       = (fa == IND_PORT0_ADDR) || (fa == IND_PORT1_ADDR);
                    pn        = (fa == IND_PORT1_ADDR);
                    // literal forms never touch the port
                    if (instr_word[13:8] == OP_ADD_LIT_ACC
                        || instr_word[13:8] == OP_AND_LIT_ACC
                        || instr_word[13:7] == OP_ADD_LIT_PTR)
                        ind = 1'b0;
                    mind_nxt  = ind;
                    maddr_nxt = ind ? ptr_r[pn] : {9'h000, fa};
                    indx_nxt  = ind && ptr_r[pn][PW-1];
                    state_nxt = ST_EXEC;
                end
                else if (psel && penable && !pready_r)
                begin
                    // answer one cycle into the access phase
                    pready_nxt  = 1'b1;
                    prdata_nxt  = pwrite ? 32'h0000_0000 : rd_val;
                    pslverr_nxt = !rd_hit;
                end
                // writes land on the edge that samples pready high
                if (psel && penable && pready_r && pwrite)
                begin
                    case (paddr)
                        REG_ACC:  acc_nxt    = pwdata[DW-1:0];
                        REG_STAT: stat_nxt   = pwdata[2:0];
                        REG_PTR0: ptr_nxt[0] = pwdata[PW-1:0];
                        REG_PTR1: ptr_nxt[1] = pwdata[PW-1:0];
                        default:  ;
                    endcase
                end
            end

            ST_EXEC:
            begin
                top6 = ir_r[13:8];
                fa   = ir_r[FW-1:0];
                dst  = ir_r[DEST_BIT];
                if (ir_r[13:7] == OP_ADD_LIT_PTR)
                begin
                    // sign-extend k; 16-bit sum drops the wrap carry
                    kx = {{(PW-6){ir_r[5]}}, ir_r[5:0]};
                    pn = ir_r[PSEL_BIT];
                    ptr_nxt[pn] = ptr_r[pn] + kx;
                end
                else if (top6 == OP_ADD_LIT_ACC)
                begin
                    opb      = ir_r[DW-1:0];
                    is_arith = 1'b1;
                end
                else if (top6 == OP_ADD_ACC_FILE)
                begin
                    opb      = file_rdata;
                    is_arith = 1'b1;
                    wr_en    = dst;
                end
                else if (top6 == OP_ADC_FILE)
                begin
                    opb      = file_rdata;
                    cin      = stat_r[ST_C_BIT];
                    is_arith = 1'b1;
                    wr_en    = dst;
                end
                else if (top6 == OP_AND_LIT_ACC)
                begin
                    res   = acc_r & ir_r[DW-1:0];
                    upd_z = 1'b1;
                end
                else if (top6 == OP_AND_ACC_FILE)
                begin
                    res   = acc_r & file_rdata;
                    upd_z = 1'b1;
                    wr_en = dst;
                end
                else if (top6 == OP_ASR_FILE)
                begin
                    res   = {file_rdata[DW-1], file_rdata[DW-1:1]};
                    new_c = file_rdata[0];
                    upd_c = 1'b1;
                    upd_z = 1'b1;
                    wr_en = dst;
                end

                // one adder serves all three additions
                if (is_arith)
                begin
                    sum9   = {1'b0, acc_r} + {1'b0, opb} + {8'h00, cin};
                    sum5   = {1'b0, acc_r[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
                    res    = sum9[DW-1:0];
                    new_c  = sum9[DW];
                    upd_c  = 1'b1;
                    upd_dc = 1'b1;
                    upd_z  = 1'b1;
                end

                // route result; literal ops always target the accumulator
                if (is_arith || upd_z)
                begin
                    if (wr_en)
                    begin
                        mwe_nxt = 1'b1;
                        mwd_nxt = res;
                    end
                    else
                        acc_nxt = res;
                end
                if (upd_c)
                    stat_nxt[ST_C_BIT] = new_c;
                if (upd_dc)
                    stat_nxt[ST_DC_BIT] = sum5[4];
                if (upd_z)
                    stat_nxt[ST_Z_BIT] = (res == 8'h00);

                // extra slots: nop after pc change, one more for slow pointer
                ext      = {1'b0, pcx_r} + {1'b0, indx_r};
                dcyc_nxt = CYC_BASE + ext;
                if (ext == 2'h0)
                begin
                    done_nxt  = 1'b1;
                    state_nxt = ST_IDLE;
                end
                else
                begin
                    cnt_nxt   = ext;
                    state_nxt = ST_NOP;
                end
            end

            ST_NOP:
            begin
                // idle slot; no state changes besides the count
                cnt_nxt = cnt_r - 2'h1;
                if (cnt_r == 2'h1)
                begin
                    done_nxt  = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end

            default:
                state_nxt = ST_IDLE;
        endcase

        // hold off new words while software owns the bus
        ready_nxt = (state_nxt == ST_IDLE) && (state_r == ST_IDLE) && !psel;
    end

    // all state registers; outputs taken straight from here
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r   <= ST_IDLE;
            ir_r      <= '0;
            pcx_r     <= 1'b0;
            indx_r    <= 1'b0;
            cnt_r     <= 2'h0;
            acc_r     <= ACC_RST;
            stat_r    <= STAT_RST;
            ptr_r[0]  <= PTR_RST;
            ptr_r[1]  <= PTR_RST;
            ready_r   <= 1'b0;
            maddr_r   <= PTR_RST;
            mind_r    <= 1'b0;
            mwe_r     <= 1'b0;
            mwd_r     <= ACC_RST;
            done_r    <= 1'b0;
            dcyc_r    <= 2'h0;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            ir_r      <= ir_nxt;
            pcx_r     <= pcx_nxt;
            indx_r    <= indx_nxt;
            cnt_r     <= cnt_nxt;
            acc_r     <= acc_nxt;
            stat_r    <= stat_nxt;
            ptr_r[0]  <= ptr_nxt[0];
            ptr_r[1]  <= ptr_nxt[1];
            ready_r   <= ready_nxt;
            maddr_r   <= maddr_nxt;
            mind_r    <= mind_nxt;
            mwe_r     <= mwe_nxt;
            mwd_r     <= mwd_nxt;
            done_r    <= done_nxt;
            dcyc_r    <= dcyc_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // port drive from flops
    assign instr_ready  = ready_r;
    assign mem_addr     = maddr_r;
    assign mem_indirect = mind_r;
    assign mem_we       = mwe_r;
    assign mem_wdata    = mwd_r;
    assign done         = done_r;
    assign done_cycles  = dcyc_r;
    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;

endmodule : cax_exec

`default_nettype wire

// file: cax_asserts.sv
// port-level checks for the add-and-shift execute datapath
// assumes one core clock and the active-low async reset
`timescale 1ns/1ps
`default_nettype none
module cax_asserts
    import cax_pkg::*;
#(
    parameter logic [5:0] OP_ADD_ACC_FILE = OP_ADD_ACC_FILE_DEF,
    parameter logic [5:0] OP_ADC_FILE     = OP_ADC_FILE_DEF,
    parameter logic [5:0] OP_AND_ACC_FILE = OP_AND_ACC_FILE_DEF,
    parameter logic [5:0] OP_ASR_FILE     = OP_ASR_FILE_DEF
)
(
    input wire logic           clk,             // clock
    input wire logic           resetn,          // reset
    input wire logic           instr_valid,     // offer
    input wire logic [OPW-1:0] instr_word,      // word
    input wire logic           instr_pc_change, // slow
    input wire logic           instr_ready,     // taken
    input wire logic [DW-1:0]  file_rdata,      // file value
    input wire logic [PW-1:0]  mem_addr,        // address
    input wire logic           mem_indirect,    // pointer
    input wire logic           mem_we,          // write
    input wire logic [DW-1:0]  mem_wdata,       // wdata
    input wire logic           done,            // retire
    input wire logic [1:0]     done_cycles,     // cycles
    input wire logic           psel,            // apb
    input wire logic           penable,         // apb
    input wire logic           pwrite,          // apb
    input wire logic [AW-1:0]  paddr,           // apb
    input wire logic [31:0]    pwdata,          // apb
    input wire logic [31:0]    prdata,          // apb
    input wire logic           pready,          // apb
    input wire logic           pslverr          // apb
);
    logic take;
    logic lit_op;
    logic file_op;
    logic direct;
    // literal and pointer ops never touch a port, so their timing is fixed
    assign take    = instr_valid && instr_ready;
    assign lit_op  = take && (instr_word[13:8] == OP_ADD_LIT_ACC
                     || instr_word[13:8] == OP_AND_LIT_ACC
                     || instr_word[13:7] == OP_ADD_LIT_PTR);
    assign file_op = take && instr_word[13:8] inside {OP_ADD_ACC_FILE, OP_ADC_FILE,
                     OP_AND_ACC_FILE, OP_ASR_FILE};
    assign direct  = file_op && instr_word[6:1] != 6'h00;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_lit_one_cyc: assert property (lit_op && !instr_pc_change |-> ##2 done && done_cycles == 2'h1)
        else $error("literal op retire wrong");
    a_pc_two_cyc: assert property (lit_op && instr_pc_change |-> ##2 !done ##1 done && done_cycles == 2'h2)
        else $error("pc change retire wrong");
    a_port_slow: assert property (file_op && !instr_pc_change && instr_word[6:1] == 6'h00 ##1
        mem_indirect && mem_addr[15] |-> !done ##1 !done ##1 done && done_cycles == 2'h2)
        else $error("slow pointer retire wrong");
    a_file_direct: assert property (direct |=> !mem_indirect && mem_addr == {9'h000, $past(instr_word[6:0])})
        else $error("direct address wrong");
    a_dest_write: assert property (direct && !instr_pc_change |-> ##2 done && mem_we == $past(instr_word[DEST_BIT], 2))
        else $error("destination routing wrong");
    a_lit_no_write: assert property (lit_op |-> ##1 !mem_we ##1 !mem_we)
        else $error("literal op wrote file");
    a_take_busy: assert property (take |=> !instr_ready && !done)
        else $error("busy engine took a word");
    a_asr_data: assert property (direct && !instr_pc_change && instr_word[13:8] == OP_ASR_FILE
        && instr_word[DEST_BIT] |=> ##1 mem_wdata == {$past(file_rdata[7]), $past(file_rdata[7:1])})
        else $error("shift result wrong");
endmodule : cax_asserts
bind cax_exec cax_asserts #(.OP_ADD_ACC_FILE(OP_ADD_ACC_FILE), .OP_ADC_FILE(OP_ADC_FILE),
    .OP_AND_ACC_FILE(OP_AND_ACC_FILE), .OP_ASR_FILE(OP_ASR_FILE)) u_asserts (.*);
`default_nettype wire

// file: cax_filemem.sv
// data memory model behind the datapath's file port
// assumes combinational reads and writes landing at the strobe's edge
`timescale 1ns/1ps
`default_nettype none
module cax_filemem
    import cax_pkg::*;
(
    input  wire logic          clk,        // core clock
    input  wire logic [PW-1:0] mem_addr,   // direct or pointer address
    input  wire logic          mem_we,     // write strobe
    input  wire logic [DW-1:0] mem_wdata,  // write data
    output var  logic [DW-1:0] file_rdata  // read data
);
    logic [DW-1:0] mem [128];
    // spread of patterns so carries and zeros both occur
    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = DW'(i * 37 + 11);
    end
    // only 128 cells: pointer targets fold onto the low seven bits
    assign file_rdata = mem[mem_addr[6:0]];
    always @(posedge clk)
    begin
        if (mem_we)
            mem[mem_addr[6:0]] <= mem_wdata;
    end
endmodule : cax_filemem
`default_nettype wire

// file: core_add_and_shift_execute_tb.sv
// self-checking bench: reference model of the datapath compared each retire
// assumes cax_filemem as data memory and the bench acting as decode
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
    $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module core_add_and_shift_execute_tb import cax_pkg::*;;
    logic           clk = 1'b0, resetn = 1'b0, instr_valid = 1'b0, instr_pc_change = 1'b0;
    logic [OPW-1:0] instr_word = '0;
    logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [AW-1:0]  paddr = '0;
    logic [31:0]    pwdata = '0, prdata, rd, seed = 32'h0000000D;
    logic           instr_ready, mem_indirect, mem_we, done, pready, pslverr;
    logic [DW-1:0]  file_rdata, mem_wdata;
    logic [PW-1:0]  mem_addr;
    logic [1:0]     done_cycles;
    logic           m_c = 1'b0, m_dc = 1'b0, m_z = 1'b0;
    int             num_errors = 0, total_checks = 0, cycles = 0, m_acc = 0, m_ptr[2] = '{0, 0};
    always #10 clk = ~clk;
    cax_exec dut (.*);
    cax_filemem u_mem (.*);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    // request held until pready is sampled high
    task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] wd);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
        @(posedge clk);
        penable <= 1'b1;
        // no cycle budget here: only the bench timeout ends a wait
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic exec(input logic [13:0] w, input logic pc);
        @(posedge clk);
        {instr_valid, instr_word, instr_pc_change} <= {1'b1, w, pc};
        do @(posedge clk); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        do @(posedge clk); while (done !== 1'b1);
    endtask : exec
    // op: 0 add lit, 1 and lit, 2 pointer add, 3 add, 4 add carry, 5 and, 6 shift
    task automatic step(input int op, input int k, input int f, input int d, input logic pc);
        int a, fv, r, cin, ad, cyc;
        logic [13:0] w;
        a = m_acc;
        cin = (op == 4) ? m_c : 0;
        ad = (f < 2) ? m_ptr[f] & 127 : f;
        fv = (op < 2) ? k & 255 : u_mem.mem[ad];
        cyc = 1 + pc + ((op > 2 && f < 2 && m_ptr[f] >= 'h8000) ? 1 : 0);
        w = (op == 0) ? {OP_ADD_LIT_ACC, k[7:0]} : (op == 1) ? {OP_AND_LIT_ACC, k[7:0]}
          : (op == 2) ? {OP_ADD_LIT_PTR, d[0], k[5:0]}
          : {op == 3 ? OP_ADD_ACC_FILE_DEF : op == 4 ? OP_ADC_FILE_DEF
          : op == 5 ? OP_AND_ACC_FILE_DEF : OP_ASR_FILE_DEF, d[0], f[6:0]};
        r = (op == 1 || op == 5) ? a & fv : (op == 6) ? (fv >> 1) | (fv & 128) : a + fv + cin;
        if (op == 0 || op == 3 || op == 4)
            {m_c, m_dc} = {r[8], 1'((((a & 15) + (fv & 15) + cin) >> 4))};
        if (op == 6)
            m_c = fv[0];
        if (op == 2)
            m_ptr[d] = (m_ptr[d] + (k[5] ? (k & 63) - 64 : k & 63)) & 'hFFFF;
        else
            m_z = (r[7:0] == 8'h00);
        if (op < 2 || (op > 2 && d == 0))
            m_acc = r & 255;
        exec(w, pc);
        `CHK("cycles", 2'(cyc), done_cycles)
        apb(1'b0, REG_INFO, '0);
        `CHK("info", {1'b0, 2'(cyc)}, rd[2:0])
        apb(1'b0, REG_ACC, '0);
        `CHK("accumulator", 8'(m_acc), rd[7:0])
        apb(1'b0, REG_STAT, '0);
        `CHK("status", {m_z, m_dc, m_c}, rd[2:0])
        apb(1'b0, REG_PTR0 + 12'(d * 4), '0);
        `CHK("pointer", 16'(m_ptr[d]), rd[15:0])
        if (op > 2 && d == 1)
            `CHK("file", 8'(r), u_mem.mem[ad])
    endtask : step
    // cut a hang short and still report
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            results();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        apb(1'b0, REG_STAT, '0);
        `CHK("status reset", 32'h00000000, rd)
        apb(1'b1, REG_PTR0, 32'h00008005);
        apb(1'b1, REG_PTR1, 32'h0000FFFF);
        {m_ptr[0], m_ptr[1]} = {32'h8005, 32'hFFFF};
        step(2, 1, 0, 1, 1'b0);
        step(2, 32, 0, 1, 1'b0);
        step(6, 0, 0, 1, 1'b1);
        // software-set accumulator and carry feed the add with carry
        apb(1'b1, REG_ACC, 32'h000000F0);
        apb(1'b1, REG_STAT, 32'h00000001);
        m_acc = 'hF0;
        {m_z, m_dc, m_c} = 3'h1;
        step(4, 0, 1, 0, 1'b0);
        apb(1'b0, 12'h020, '0);
        `CHK("unmapped error", 1'b1, err)
        // second reset mid-run: registers return to zero, memory keeps its data
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        m_acc = 0;
        m_ptr = '{0, 0};
        {m_z, m_dc, m_c} = 3'h0;
        apb(1'b0, REG_ACC, '0);
        `CHK("accumulator reset", 32'h00000000, rd)
        apb(1'b0, REG_PTR1, '0);
        `CHK("pointer reset", 32'h00000000, rd)
        $display("test directed done");
        repeat (60)
            step(int'(rnd() % 7), int'(rnd() & 255),
                 int'(rnd() % 3 == 0 ? rnd() & 1 : rnd() & 127), int'(rnd() & 1), rnd() % 5 == 0);
        $display("test random done");
        results();
    end
endmodule : core_add_and_shift_execute_tb
`default_nettype wire
